// *** logic/cpu_bus_cycle_cache_control.sv ***
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps
module cpu_bus_cycle_cache_control (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_hsel,
	input wire logic [cpu_bus_pkg::ADDR_W-1:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [cpu_bus_pkg::DATA_W-1:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic [cpu_bus_pkg::DATA_W-1:0] o_hrdata,
	input wire logic i_burst_ready,
	input wire logic i_next_cycle_accept,
	input wire logic i_cacheability_ack,
	input wire logic i_backoff_abort,
	input wire logic i_hold_req,
	input wire logic i_snoop_address_strobe,
	input wire logic i_snoop_invalidate_req,
	input wire logic i_snoop_hit,
	input wire logic i_unmaskable_irq,
	input wire logic i_instr_boundary,
	input wire logic i_system_mgmt_mode,
	input wire logic i_interrupt_return,
	output logic o_address_strobe,
	output logic o_write_cycle,
	output logic o_line_fill_intent,
	output logic o_atomic_sequence_hold,
	output logic o_atomic_sequence_hold_oe_n,
	output logic o_space_select,
	output logic o_space_select_oe_n,
	output logic o_page_nocache,
	output logic o_page_nocache_oe_n,
	output logic o_hold_grant,
	output logic o_nmi_take
);
	import cpu_bus_pkg::*;

	logic wr_pend;
	logic [OFS_HI:0] wr_ofs;
	logic cd_bit, pg_bit, base_pcd;
	logic req_valid;
	logic [CYC_W-1:0] req;
	logic aborted, last_cached;
	line_state_e line_st, wb_tgt;
	logic wb_req;
	logic [1:0] n;
	slot_s h, s, new_slot;
	logic [1:0] h_cnt;
	logic h_ken_seen, h_ken;
	logic na_seen, skip_na, ads_second, lock_gap;
	logic nmi_pending, nmi_in_handler;
	logic [DATA_W-1:0] rd_data, status_word;

	////////////////////////////////////////////////////////////////////////
	// register bus decode
	wire ahb_take = i_hsel & i_htrans[HTRANS_ACT] & i_hready;
	wire [OFS_HI:0] rd_ofs = i_haddr[OFS_HI:0];
	wire wr_ctrl = wr_pend & (wr_ofs == OFS_CTRL);
	wire wr_cycle = wr_pend & (wr_ofs == OFS_CYCLE);
	wire wr_line = wr_pend & (wr_ofs == OFS_LINE);
	assign status_word = {8'h00, NMI_VECTOR, 4'h0, wb_req, nmi_in_handler,
		nmi_pending, aborted, last_cached, line_st, o_hold_grant,
		o_atomic_sequence_hold, req_valid, n};
	assign rd_data = (rd_ofs == OFS_CTRL) ?
			{29'h0, base_pcd, pg_bit, cd_bit} :
		(rd_ofs == OFS_CYCLE) ? {{(DATA_W-CYC_W){1'b0}}, req} :
		(rd_ofs == OFS_STATUS) ? status_word :
		(rd_ofs == OFS_LINE) ? {30'h0, line_st} : '0;

	////////////////////////////////////////////////////////////////////////
	// page attribute and request slot
	wire [1:0] req_cls = req[CYC_CLS+:2];
	wire ent_pcd = (req_cls == CLS_DIR) ? req[CYC_DIR_PCD] :
		req[CYC_PTE_PCD];
	wire req_pcd = !pg_bit ? cd_bit :
		(req_cls == CLS_NONPAGED) ? base_pcd : ent_pcd;
	wire req_lock = req[CYC_LOCK];
	wire lock_start = req_lock & !o_atomic_sequence_hold;
	wire need_flush = req_valid & lock_start & (line_st != LINE_INV);
	// locked reads never fill; writes only mark fill for writebacks
	wire req_fill = req[CYC_FILL] & !req[CYC_WRITE] & !req_lock;
	assign new_slot = wb_req ? WB_SLOT : '{write: req[CYC_WRITE],
		fill: req_fill, mem: req[CYC_MEM], page_nocache: req_pcd, lock: req_lock,
		lock_end: req[CYC_LOCK_END], wb: 1'b0};

	////////////////////////////////////////////////////////////////////////
	// cycle tracking, beats and issue
	wire ken_now = h_ken_seen ? h_ken : i_cacheability_ack;
	wire h_burst = h.wb | (!h.write & h.fill & ken_now);
	wire [1:0] h_last = h_burst ? BURST_LAST : SINGLE_LAST;
	wire busy = (n != 2'h0);
	wire head_done = busy & i_burst_ready & (h_cnt == h_last);
	wire ken_take = busy & !h_ken_seen & !h.write & h.fill & !h.wb &
		(i_burst_ready | i_next_cycle_accept);
	wire [1:0] eff_n = n - {1'b0, head_done};
	wire end_pending = (busy & h.lock_end) | ((n == 2'h2) & s.lock_end);
	wire slot_free = (n == 2'h0) | ((n == 2'h1) & na_seen);
	wire yield = i_hold_req & !o_atomic_sequence_hold;
	wire src_ok = wb_req | (req_valid & !need_flush &
		!(req_lock & (end_pending | (lock_start & lock_gap))));
	wire issue = src_ok & slot_free & !o_address_strobe &
		!i_backoff_abort & !o_hold_grant & !yield;
	wire [1:0] next_n = eff_n + {1'b0, issue};
	wire na_sample = i_next_cycle_accept & busy & !o_address_strobe &
		!skip_na;
	wire grant_next = i_hold_req & (o_hold_grant | (!busy &
		!o_atomic_sequence_hold & !o_address_strobe));
	wire wb_busy = wb_req | (busy & h.wb) | ((n == 2'h2) & s.wb);
	wire fill_ok = !h.write & h.fill & ken_now & !h.page_nocache & !h.lock;

	////////////////////////////////////////////////////////////////////////
	// snoop decode
	wire snoop_hit = i_snoop_address_strobe & i_snoop_hit &
		(line_st != LINE_INV);
	wire line_state_e snoop_tgt = i_snoop_invalidate_req ? LINE_INV :
		LINE_SHR;

	////////////////////////////////////////////////////////////////////////
	// register slave and software registers
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			wr_pend <= 1'b0;
			wr_ofs <= '0;
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
			o_hrdata <= '0;
			cd_bit <= CTRL_CD_RESET;
			pg_bit <= 1'b0;
			base_pcd <= 1'b0;
			req_valid <= 1'b0;
			req <= '0;
			aborted <= 1'b0;
		end else begin
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
			if (i_hready) begin
				wr_pend <= ahb_take & i_hwrite;
				wr_ofs <= i_haddr[OFS_HI:0];
			end
			o_hrdata <= (ahb_take & !i_hwrite) ? rd_data : '0;
			if (wr_ctrl) begin
				cd_bit <= i_hwdata[CTRL_CD];
				pg_bit <= i_hwdata[CTRL_PG];
				base_pcd <= i_hwdata[CTRL_BASE_PCD];
			end
			if (issue & !wb_req)
				req_valid <= 1'b0;
			if (wr_cycle & !req_valid) begin
				req_valid <= 1'b1;
				req <= i_hwdata[CYC_W-1:0];
			end
			if (wr_cycle)
				aborted <= 1'b0;
			if (i_backoff_abort & busy)
				aborted <= 1'b1;
		end
	end

	// outstanding cycle slots; backoff drops every cycle in flight
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst | i_backoff_abort) begin
			n <= 2'h0;
			h <= '0;
			s <= '0;
			h_cnt <= 2'h0;
			h_ken_seen <= 1'b0;
			h_ken <= 1'b0;
		end else begin
			n <= next_n;
			if (head_done) begin
				h <= s;
				h_cnt <= 2'h0;
				h_ken_seen <= 1'b0;
			end else begin
				if (busy & i_burst_ready)
					h_cnt <= h_cnt + 2'h1;
				if (ken_take) begin
					h_ken_seen <= 1'b1;
					h_ken <= i_cacheability_ack;
				end
			end
			if (issue & (eff_n == 2'h0))
				h <= new_slot;
			else if (issue)
				s <= new_slot;
		end
	end

	// next-accept latch and its skipped edge
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst | i_backoff_abort) begin
			na_seen <= 1'b0;
			ads_second <= 1'b0;
			skip_na <= 1'b0;
		end else begin
			ads_second <= issue & (eff_n == 2'h1);
			skip_na <= o_address_strobe & ads_second;
			if (issue)
				na_seen <= 1'b0;
			else if (na_sample)
				na_seen <= 1'b1;
		end
	end

	// bus pins: strobe, attributes, lock, hold grant and floating
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			o_address_strobe <= 1'b0;
			o_write_cycle <= 1'b0;
			o_line_fill_intent <= 1'b0;
			o_space_select <= 1'b0;
			o_page_nocache <= 1'b0;
			o_atomic_sequence_hold <= 1'b0;
			lock_gap <= 1'b0;
			o_hold_grant <= 1'b0;
			o_atomic_sequence_hold_oe_n <= 1'b0;
			o_space_select_oe_n <= 1'b0;
			o_page_nocache_oe_n <= 1'b0;
		end else begin
			o_address_strobe <= issue;
			if (issue) begin
				o_write_cycle <= new_slot.write;
				o_line_fill_intent <= new_slot.fill | new_slot.wb;
				o_space_select <= new_slot.mem;
				o_page_nocache <= new_slot.page_nocache;
			end
			lock_gap <= head_done & h.lock_end;
			if (head_done & h.lock_end)
				o_atomic_sequence_hold <= 1'b0;
			if (issue & new_slot.lock)
				o_atomic_sequence_hold <= 1'b1;
			o_hold_grant <= grant_next;
			o_atomic_sequence_hold_oe_n <= grant_next | i_backoff_abort;
			o_space_select_oe_n <= grant_next | i_backoff_abort;
			o_page_nocache_oe_n <= grant_next | i_backoff_abort;
		end
	end

	// one-line cache state, snoops, flushes and writebacks
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			line_st <= LINE_INV;
			wb_tgt <= LINE_INV;
			wb_req <= 1'b0;
			last_cached <= 1'b0;
		end else begin
			if (head_done & !h.write)
				last_cached <= fill_ok;
			if (head_done & fill_ok)
				line_st <= LINE_EXC;
			if (head_done & h.wb)
				line_st <= wb_tgt;
			if (issue & wb_req)
				wb_req <= 1'b0;
			if (i_backoff_abort & wb_busy)
				wb_req <= 1'b1;
			if (need_flush & !wb_busy) begin
				if (line_st == LINE_MOD) begin
					wb_req <= 1'b1;
					wb_tgt <= LINE_INV;
				end else
					line_st <= LINE_INV;
			end
			if (snoop_hit & !wb_busy) begin
				if (line_st == LINE_MOD) begin
					wb_req <= 1'b1;
					wb_tgt <= snoop_tgt;
				end else
					line_st <= snoop_tgt;
			end else if (snoop_hit & i_snoop_invalidate_req)
				wb_tgt <= LINE_INV;
			if (wr_line)
				line_st <= line_state_e'(i_hwdata[1:0]);
		end
	end

	// unmaskable request latch
	nmi_request_latch nmi_latch (
		.i_mclk(i_mclk),
		.i_sys_rst(i_sys_rst),
		.i_irq(i_unmaskable_irq),
		.i_boundary(i_instr_boundary),
		.i_smm(i_system_mgmt_mode),
		.i_return(i_interrupt_return),
		.o_take(o_nmi_take),
		.o_pending(nmi_pending),
		.o_in_handler(nmi_in_handler)
	);

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_sys_rst);

	sequence s_lock_release;
		$fell(o_atomic_sequence_hold);
	endsequence
	sequence s_abort;
		i_backoff_abort;
	endsequence

	property p_snoop_state;
		(snoop_hit && line_st != LINE_MOD && !wb_busy && !wr_line)
			|=> line_st == $past(snoop_tgt);
	endproperty
	a_snoop_state: assert property (p_snoop_state)
		else $error("snoop left line in wrong state");
	property p_wb_first;
		(snoop_hit && line_st == LINE_MOD && !wb_busy && !wr_line)
			|=> (wb_req && line_st == LINE_MOD);
	endproperty
	a_wb_first: assert property (p_wb_first)
		else $error("modified line changed before writeback");
	property p_burst_len;
		(head_done && !h.write && h.fill && ken_now) |-> h_cnt == BURST_LAST;
	endproperty
	a_burst_len: assert property (p_burst_len)
		else $error("fill burst ended early");
	property p_single_read;
		(head_done && !h.write && !ken_now) |=> !last_cached;
	endproperty
	a_single_read: assert property (p_single_read)
		else $error("uncacheable read was cached");
	property p_pcd_nocache;
		(head_done && h.page_nocache) |=> !last_cached;
	endproperty
	a_pcd_nocache: assert property (p_pcd_nocache)
		else $error("page_nocache read was cached");
	property p_lock_with_ads;
		$rose(o_atomic_sequence_hold) |-> o_address_strobe;
	endproperty
	a_lock_with_ads: assert property (p_lock_with_ads)
		else $error("atomic hold rose without address strobe");
	property p_lock_gap;
		s_lock_release |=> !o_atomic_sequence_hold;
	endproperty
	a_lock_gap: assert property (p_lock_gap)
		else $error("no idle clock between locked sequences");
	property p_float;
		s_abort |=> (o_atomic_sequence_hold_oe_n && o_space_select_oe_n
			&& o_page_nocache_oe_n);
	endproperty
	a_float: assert property (p_float)
		else $error("pins not floated after backoff");
	property p_attr_steady;
		($changed(o_space_select) || $changed(o_page_nocache))
			|-> o_address_strobe;
	endproperty
	a_attr_steady: assert property (p_attr_steady)
		else $error("cycle attributes changed mid cycle");
	property p_two_max;
		(n == 2'h2) |=> !o_address_strobe;
	endproperty
	a_two_max: assert property (p_two_max)
		else $error("third cycle started");
	property p_na_skip;
		(skip_na && !na_seen) |=> !na_seen;
	endproperty
	a_na_skip: assert property (p_na_skip)
		else $error("next accept taken on skipped edge");
endmodule : cpu_bus_cycle_cache_control

// *** logic/cpu_bus_pkg.sv ***
// Summary of operation
// - snoop hit goes invalid when invalidate request set, else to shared
// - snooped modified line is written back before its state changes
// - invalidate request is looked at only with the snoop address strobe
// - cacheable fill read runs a burst of four burst_ready beats
// - read without cacheability ack is one transfer and is not cached
// - writes mark fill intent only for writebacks, which ignore the ack
// - page_nocache cycles are never cached whatever the ack says
// - ack sampled at first burst_ready or next-accept of fill reads only
// - atomic hold covers locked sequences of any length, up to the cycle marked lock end
// - lines are flushed before locked operations; locked reads not cached
// - atomic hold rises with address strobe, ends at final last beat
// - atomic hold stays low at least two clocks between locked sequences
// - hold, space and nocache pins float on backoff and on hold grant
// - space_select high for memory, low for i/o port accesses
// - space and nocache set with address strobe, steady until cycle ends
// - next accept latched; at most two cycles outstanding
// - next accept sampled during cycles, skipping one edge for second
// - unmaskable request vectors to 02h, masked in system management mode
// - unmaskable request is latched on its rising edge, taken at boundary
// - page_nocache chosen from cache disable, base, directory or table bit
package cpu_bus_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 32;
	localparam int OFS_HI = 3;
	localparam int HTRANS_ACT = 1;
	// register byte offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_CYCLE = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h8;
	localparam logic [3:0] OFS_LINE = 4'hC;
	// control register fields
	localparam int CTRL_CD = 0;
	localparam int CTRL_PG = 1;
	localparam int CTRL_BASE_PCD = 2;
	localparam logic CTRL_CD_RESET = 1'b1;
	// cycle request fields
	localparam int CYC_W = 9;
	localparam int CYC_WRITE = 0;
	localparam int CYC_FILL = 1;
	localparam int CYC_MEM = 2;
	localparam int CYC_LOCK = 3;
	localparam int CYC_LOCK_END = 4;
	localparam int CYC_CLS = 5;
	localparam int CYC_DIR_PCD = 7;
	localparam int CYC_PTE_PCD = 8;
	localparam logic [1:0] CLS_NONPAGED = 2'h0;
	localparam logic [1:0] CLS_DIR = 2'h1;
	// burst beat indexes
	localparam logic [1:0] BURST_LAST = 2'h3;
	localparam logic [1:0] SINGLE_LAST = 2'h0;
	localparam logic [7:0] NMI_VECTOR = 8'h02;
	typedef enum logic [1:0] {LINE_INV, LINE_SHR, LINE_EXC, LINE_MOD}
		line_state_e;
	typedef struct packed {
		logic write;
		logic fill;
		logic mem;
		logic page_nocache;
		logic lock;
		logic lock_end;
		logic wb;
	} slot_s;
	// writeback: memory write with fill mark, never a lock end
	localparam slot_s WB_SLOT = 7'h71;
endpackage : cpu_bus_pkg

// *** logic/nmi_request_latch.sv ***
`timescale 1ns/100ps
module nmi_request_latch (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_irq,
	input wire logic i_boundary,
	input wire logic i_smm,
	input wire logic i_return,
	output logic o_take,
	output logic o_pending,
	output logic o_in_handler
);
	logic irq_prev;
	wire rise = i_irq & !irq_prev;
	wire take = o_pending & i_boundary & !o_in_handler & !i_smm;

	// rising edge latch, taken at a boundary outside the handler
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			irq_prev <= 1'b0;
			o_take <= 1'b0;
			o_pending <= 1'b0;
			o_in_handler <= 1'b0;
		end else begin
			irq_prev <= i_irq;
			o_take <= take;
			if (take)
				o_pending <= 1'b0;
			if (rise)
				o_pending <= 1'b1;
			if (i_return)
				o_in_handler <= 1'b0;
			if (take)
				o_in_handler <= 1'b1;
		end
	end
endmodule : nmi_request_latch

// *** verif/bus_partner.sv ***
`timescale 1ns/100ps
module bus_partner (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_strobe,
	input wire logic i_write,
	input wire logic i_fill,
	input wire logic i_abort,
	input wire logic i_ack_level,
	input wire logic i_slow,
	output logic o_burst_ready,
	output logic o_ack
);
	logic [2:0] left;
	logic gap;
	logic four;
	////////////////////////////////////////////////////////////////////////
	// beats are offered while some remain and no wait state is due
	assign o_burst_ready = (left != 3'h0) && !gap;
	// ack stands with the open cycle, inverted once nothing is open
	assign o_ack = (left != 3'h0) ? i_ack_level : ~i_ack_level;
	// fills answered cacheable and writebacks take four beats
	assign four = i_fill && (i_write || i_ack_level);
	// beat counter, dropped on backoff; slow mode puts a gap before each beat
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst || i_abort) begin
			left <= 3'h0;
			gap <= 1'b0;
		end else if (i_strobe) begin
			left <= four ? 3'h4 : 3'h1;
			gap <= i_slow;
		end else if (left != 3'h0) begin
			left <= left - {2'h0, o_burst_ready};
			gap <= i_slow && o_burst_ready;
		end
	end
endmodule : bus_partner

// *** verif/cpu_bus_cycle_cache_control_test.sv ***
`timescale 1ns/100ps
module cpu_bus_cycle_cache_control_test;
	import cpu_bus_pkg::*;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic hsel = 1'b0;
	logic [ADDR_W-1:0] haddr = '0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [DATA_W-1:0] hwdata = '0;
	logic snp = 1'b0, snoop_invalidate_req = 1'b0, hit = 1'b0, backoff_abort = 1'b0, irq = 1'b0;
	logic bnd = 1'b0, interrupt_return = 1'b0, ack_lvl = 1'b0, slow = 1'b0;
	logic hreq = 1'b0;
	wire logic hready, hresp, burst_ready, ack, strobe, wcyc, fill, hold, hold_oe_n;
	wire logic space, space_oe_n, page_nocache, pcd_oe_n, hold_grant, take;
	wire logic [DATA_W-1:0] hrdata;
	int error_cnt = 0;
	int n_compared = 0;
	////////////////////////////////////////////////////////////////////////
	cpu_bus_cycle_cache_control dut (.i_mclk(mclk), .i_sys_rst(sys_rst),
		.i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
		.o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
		.i_burst_ready(burst_ready), .i_next_cycle_accept(1'b0),
		.i_cacheability_ack(ack), .i_backoff_abort(backoff_abort), .i_hold_req(hreq),
		.i_snoop_address_strobe(snp), .i_snoop_invalidate_req(snoop_invalidate_req),
		.i_snoop_hit(hit), .i_unmaskable_irq(irq), .i_instr_boundary(bnd),
		.i_system_mgmt_mode(1'b0), .i_interrupt_return(interrupt_return),
		.o_address_strobe(strobe), .o_write_cycle(wcyc),
		.o_line_fill_intent(fill), .o_atomic_sequence_hold(hold),
		.o_atomic_sequence_hold_oe_n(hold_oe_n), .o_space_select(space),
		.o_space_select_oe_n(space_oe_n), .o_page_nocache(page_nocache),
		.o_page_nocache_oe_n(pcd_oe_n), .o_hold_grant(hold_grant),
		.o_nmi_take(take));
	bus_partner partner (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_strobe(strobe),
		.i_write(wcyc), .i_fill(fill), .i_abort(backoff_abort), .i_ack_level(ack_lvl),
		.i_slow(slow), .o_burst_ready(burst_ready), .o_ack(ack));
	////////////////////////////////////////////////////////////////////////
	// clock, 8 ns period
	initial begin
		forever #4 mclk = ~mclk;
	end
	// count a comparison and report a mismatch
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		n_compared++;
		if (got !== exp) begin
			$display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
			error_cnt++;
		end
	endtask : chk
	// one single ahb-lite transfer, address phase then data phase
	task automatic bus(input logic w, input logic [3:0] ofs,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {28'h0, ofs};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge mclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk); while (hready !== 1'b1);
		// taken at the closing edge, before the slave updates
		rd = hrdata;
		chk(hresp, 1'b0, "bus response");
	endtask : bus
	// wait, bounded, for the next address strobe; returns settled after it
	task automatic wait_strobe();
		int n;
		for (n = 0; n < 40; n++) begin
			@(posedge mclk);
			#1;
			if (strobe === 1'b1) break;
		end
		chk(n < 40, 1, "no address strobe");
	endtask : wait_strobe
	// count beats offered from now, checking space and nocache stay put
	task automatic beats_of(output int beats);
		logic sp, pc;
		sp = space;
		pc = page_nocache;
		beats = 0;
		repeat (14) begin
			if (burst_ready === 1'b1) beats++;
			chk({space, page_nocache}, {sp, pc}, "status moved in cycle");
			@(posedge mclk);
			#1;
		end
	endtask : beats_of
	// issue one read cycle and judge beats, pins and caching
	task automatic t_cycle(input logic [8:0] cyc, input logic [2:0] ctrl,
		input logic ackv, input logic slw, input logic exp_pcd);
		logic [31:0] rd;
		int n;
		logic cached;
		cached = cyc[CYC_FILL] && ackv && !exp_pcd;
		ack_lvl <= ackv;
		slow <= slw;
		bus(1'b1, OFS_CTRL, {29'h0, ctrl}, rd);
		bus(1'b1, OFS_LINE, 32'h0, rd);
		bus(1'b1, OFS_CYCLE, {23'h0, cyc}, rd);
		wait_strobe();
		chk(space, cyc[CYC_MEM], "space select");
		chk(page_nocache, exp_pcd, "page nocache");
		beats_of(n);
		chk(n, (cyc[CYC_FILL] && ackv) ? 4 : 1, "beat count");
		bus(1'b0, OFS_STATUS, 32'h0, rd);
		chk(rd[7], cached, "cached flag");
		chk(rd[6:5], cached ? 2'h2 : 2'h0, "line after read");
		$display("cycle test %0h done", cyc);
	endtask : t_cycle
	// snoop the line from a given state and judge writeback and new state
	task automatic t_snoop(input logic [1:0] st, input logic invv,
		input logic [1:0] exp);
		logic [31:0] rd;
		int n;
		bus(1'b1, OFS_LINE, {30'h0, st}, rd);
		ack_lvl <= 1'b0;
		@(posedge mclk);
		snp <= 1'b1;
		snoop_invalidate_req <= invv;
		hit <= 1'b1;
		@(posedge mclk);
		snp <= 1'b0;
		snoop_invalidate_req <= ~invv;
		hit <= 1'b0;
		if (st == LINE_MOD) begin
			wait_strobe();
			chk({wcyc, fill, space}, 3'h7, "writeback marks");
			beats_of(n);
			chk(n, 4, "writeback beats");
		end
		repeat (4) @(posedge mclk);
		bus(1'b0, OFS_STATUS, 32'h0, rd);
		chk(rd[6:5], exp, "line state after snoop");
		snoop_invalidate_req <= 1'b0;
		$display("snoop test %0h done", st);
	endtask : t_snoop
	// two-cycle locked sequence
	task automatic t_lock();
		logic [31:0] rd;
		int n;
		ack_lvl <= 1'b1;
		slow <= 1'b0;
		bus(1'b1, OFS_CTRL, 32'h0, rd);
		bus(1'b1, OFS_CYCLE, 32'h00E, rd);
		wait_strobe();
		chk({hold, hold_oe_n, fill}, 3'h4, "first locked");
		bus(1'b1, OFS_CYCLE, 32'h01C, rd);
		wait_strobe();
		chk(hold, 1'b1, "lock held into second cycle");
		beats_of(n);
		chk(hold, 1'b0, "lock released");
		bus(1'b0, OFS_STATUS, 32'h0, rd);
		chk(rd[7], 1'b0, "locked read cached");
		$display("lock test done");
	endtask : t_lock
	// backoff during a slow cycle floats the pins and drops the cycle
	task automatic t_backoff();
		logic [31:0] rd;
		slow <= 1'b1;
		bus(1'b1, OFS_CYCLE, 32'h004, rd);
		wait_strobe();
		// no other master runs here, so backoff is raised by the bench
		backoff_abort <= 1'b1;
		@(posedge mclk);
		#1;
		chk({hold_oe_n, space_oe_n, pcd_oe_n}, 3'h7, "float");
		backoff_abort <= 1'b0;
		repeat (3) @(posedge mclk);
		bus(1'b0, OFS_STATUS, 32'h0, rd);
		chk({rd[8], rd[1:0]}, 3'h4, "aborted status");
		slow <= 1'b0;
		$display("backoff test done");
	endtask : t_backoff
	// hold request on an idle bus grants and floats, release drives again
	task automatic t_hold();
		@(posedge mclk);
		hreq <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		chk({hold_grant, hold_oe_n, space_oe_n, pcd_oe_n}, 4'hF, "hold");
		@(posedge mclk);
		hreq <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk({hold_grant, hold_oe_n, space_oe_n, pcd_oe_n}, 4'h0, "unhold");
		$display("hold test done");
	endtask : t_hold
	// count nmi takes over a few cycles
	task automatic takes(output int n);
		n = 0;
		repeat (8) begin
			@(posedge mclk);
			#1;
			if (take === 1'b1) n++;
		end
	endtask : takes
	// nmi taken once, a repeat held until the return
	task automatic t_nmi();
		int n;
		@(posedge mclk);
		irq <= 1'b1;
		@(posedge mclk);
		irq <= 1'b0;
		bnd <= 1'b1;
		takes(n);
		chk(n, 1, "nmi taken once");
		@(posedge mclk);
		irq <= 1'b1;
		@(posedge mclk);
		irq <= 1'b0;
		takes(n);
		chk(n, 0, "nmi in handler");
		@(posedge mclk);
		interrupt_return <= 1'b1;
		@(posedge mclk);
		interrupt_return <= 1'b0;
		takes(n);
		chk(n, 1, "nmi after return");
		bnd <= 1'b0;
		$display("nmi test done");
	endtask : t_nmi
	// verdict and end of run
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done
	// watchdog
	initial begin
		#200000;
		error_cnt++;
		test_done();
	end
	// main sequence
	initial begin
		logic [31:0] rd;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		chk({hold_oe_n, space_oe_n, pcd_oe_n}, 3'h0, "reset drive");
		bus(1'b0, OFS_CTRL, 32'h0, rd);
		chk(rd[2:0], 3'h1, "ctrl reset");
		bus(1'b1, OFS_STATUS, 32'hFFFF_FFFF, rd);
		bus(1'b0, OFS_STATUS, 32'h0, rd);
		chk({rd[23:16], rd[6:5]}, {NMI_VECTOR, 2'h0}, "status");
		t_cycle(9'h006, 3'h0, 1'b1, 1'b0, 1'b0);
		t_cycle(9'h006, 3'h0, 1'b0, 1'b1, 1'b0);
		t_cycle(9'h006, 3'h1, 1'b1, 1'b0, 1'b1);
		t_cycle(9'h006, 3'h6, 1'b1, 1'b1, 1'b1);
		t_cycle(9'h0A6, 3'h2, 1'b1, 1'b0, 1'b1);
		t_cycle(9'h0C6, 3'h6, 1'b1, 1'b0, 1'b0);
		t_cycle(9'h000, 3'h0, 1'b1, 1'b0, 1'b0);
		t_snoop(LINE_MOD, 1'b1, LINE_INV);
		t_snoop(LINE_EXC, 1'b0, LINE_SHR);
		t_snoop(LINE_MOD, 1'b0, LINE_SHR);
		t_lock();
		t_backoff();
		t_hold();
		t_nmi();
		test_done();
	end
endmodule : cpu_bus_cycle_cache_control_test
